// [rtl/tsrs_params.svh]
// timing and reset constants for the triple supply reset sequencer
`ifndef TSRS_PARAMS_SVH
`define TSRS_PARAMS_SVH
`define TSRS_CLK_HZ 10000000
`define TSRS_RELEASE_MS 200
`define TSRS_DEBOUNCE_MS 20
`define TSRS_HOLD_MS 2000
`define TSRS_SOFT_US 100
`define TSRS_UV_US 13
`define TSRS_RELEASE_CYC ((`TSRS_CLK_HZ / 1000) * `TSRS_RELEASE_MS)
`define TSRS_DEBOUNCE_CYC ((`TSRS_CLK_HZ / 1000) * `TSRS_DEBOUNCE_MS)
`define TSRS_HOLD_CYC ((`TSRS_CLK_HZ / 1000) * `TSRS_HOLD_MS)
`define TSRS_SOFT_CYC ((`TSRS_CLK_HZ / 1000000) * `TSRS_SOFT_US)
`define TSRS_UV_CYC ((`TSRS_CLK_HZ / 1000000) * `TSRS_UV_US)
`define TSRS_SYNC_RST 3'h0
`endif

// [rtl/tsrs_pkg.sv]
// types for the triple supply reset sequencer
package tsrs_pkg;
   typedef enum logic [3:0] {
      TSRS_PB_IDLE = 4'b0001,
      TSRS_PB_PRESS = 4'b0010,
      TSRS_PB_DEBOUNCE = 4'b0100,
      TSRS_PB_PULSE = 4'b1000
   } tsrs_pb_e;
   typedef logic [31:0] tsrs_cnt_t;
endpackage

// [rtl/tsrs_filter.sv]
// synchroniser and persistence filter for one input
`timescale 1ns/1ns
`default_nettype none
`include "tsrs_params.svh"
module tsrs_filter
   import tsrs_pkg::*;
#(
   parameter int unsigned DELAY_CYC = 1,
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic raw_in,
   output logic filt_out
);
   logic [2:0] sync;
   tsrs_cnt_t cnt;
   logic stable;
   // ****************************************
   // three stage synchroniser
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync <= {3{RST_VAL}};
      end else if (clk_en) begin
         sync <= {sync[1:0], raw_in};
      end
   end
   assign stable = (sync[1] == sync[2]);
   // ****************************************
   // level must persist before it is taken
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 32'h0000_0000;
         filt_out <= RST_VAL;
      end else if (clk_en) begin
         if (!stable || sync[2] == filt_out) begin
            cnt <= 32'h0000_0000;
         end else if (cnt >= DELAY_CYC - 1) begin
            cnt <= 32'h0000_0000;
            filt_out <= sync[2];
         end else begin
            cnt <= cnt + 32'h0000_0001;
         end
      end
   end
endmodule
`default_nettype wire

// [rtl/tsrs_top.sv]
// triple supply reset sequencer top
// Function
// RULE_01 - reset held until all supplies valid continuously for 200ms, then released
// RULE_02 - reset low while any monitored supply is under threshold
// RULE_03 - supply dip after release reasserts reset and restarts the 200ms delay
// RULE_04 - active-high reset is always the inverse of active-low reset
// RULE_05 - undervoltage recognised only after about 13us, shorter glitches ignored
// RULE_06 - short button press then release gives one 100us soft reset pulse
// RULE_07 - soft pulse starts after a 20ms debounce following button release
// RULE_08 - button held over 2 seconds asserts both system reset outputs
// RULE_09 - hold expiry clears release counter; 200ms counted after button release
// RULE_10 - during supply reset the button gives no soft reset, output stays high
// RULE_11 - button low through supply reset keeps reset until 200ms after release
// RULE_12 - 5V sense tracking 3.3V and below 4.15V disables 5V condition
// RULE_13 - tracking above 4.15V enables 5V condition and disables 3.3V condition
// RULE_14 - all intervals from counters on one clock, restarted by their start event
`timescale 1ns/1ns
`default_nettype none
`include "tsrs_params.svh"
module tsrs_top
   import tsrs_pkg::*;
#(
   parameter int unsigned RELEASE_CYC = `TSRS_RELEASE_CYC,
   parameter int unsigned DEBOUNCE_CYC = `TSRS_DEBOUNCE_CYC,
   parameter int unsigned HOLD_CYC = `TSRS_HOLD_CYC,
   parameter int unsigned SOFT_CYC = `TSRS_SOFT_CYC,
   parameter int unsigned UV_CYC = `TSRS_UV_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic sense_3v3_ok,
   input wire logic sense_5v_ok,
   input wire logic sense_adjustable_ok,
   input wire logic sense_5v_tracks_3v3,
   input wire logic sense_5v_above_4v15,
   input wire logic push_button_n,
   output logic system_reset_n,
   output logic system_reset,
   output logic soft_reset_n
);
   logic uv_3v3, uv_5v, uv_adj, track_q, high_q, pb_q;
   logic en_3v3, en_5v, supply_bad, hard_hold, pb_hold;
   logic [2:0] uv_raw, uv_q;
   tsrs_cnt_t rel_cnt, pb_cnt;
   tsrs_pb_e pb_state;
   // ****************************************
   // hold time decode
   // ****************************************
   function automatic logic hold_done(input tsrs_cnt_t cnt);
      return cnt >= HOLD_CYC - 1;
   endfunction
   // ****************************************
   // input filtering
   // ****************************************
   // undervoltage taken after the comparator response time
   assign uv_raw = {~sense_adjustable_ok, ~sense_5v_ok, ~sense_3v3_ok};
   for (genvar gi = 0; gi < 3; gi++) begin : g_uv
      tsrs_filter #(
         .DELAY_CYC(UV_CYC),
         .RST_VAL(1'b1)
      ) u_uv ( // RULE_05
         .clk_sys(clk_sys),
         .rst_n(rst_n),
         .clk_en(clk_en),
         .raw_in(uv_raw[gi]),
         .filt_out(uv_q[gi])
      );
   end
   assign uv_3v3 = uv_q[0];
   assign uv_5v = uv_q[1];
   assign uv_adj = uv_q[2];
   tsrs_filter #(
      .DELAY_CYC(1),
      .RST_VAL(1'b0)
   ) u_trk (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .raw_in(sense_5v_tracks_3v3),
      .filt_out(track_q)
   );
   tsrs_filter #(
      .DELAY_CYC(1),
      .RST_VAL(1'b0)
   ) u_hi (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .raw_in(sense_5v_above_4v15),
      .filt_out(high_q)
   );
   tsrs_filter #(
      .DELAY_CYC(1),
      .RST_VAL(1'b1)
   ) u_pb (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .raw_in(push_button_n),
      .filt_out(pb_q)
   );
   // ****************************************
   // supply override selection
   // ****************************************
   assign en_5v = !(track_q && !high_q); // RULE_12
   assign en_3v3 = !(track_q && high_q); // RULE_13
   assign supply_bad = (en_3v3 && uv_3v3) || (en_5v && uv_5v) || uv_adj; // RULE_02
   assign pb_hold = !pb_q && !system_reset_n; // RULE_11
   // ****************************************
   // release counter
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rel_cnt <= 32'h0000_0000;
         system_reset_n <= 1'b0;
      end else if (clk_en) begin
         if (supply_bad || hard_hold || pb_hold) begin // RULE_03 RULE_09 RULE_11
            rel_cnt <= 32'h0000_0000;
            system_reset_n <= 1'b0; // RULE_02 RULE_08
         end else if (!system_reset_n) begin
            if (rel_cnt >= RELEASE_CYC - 1) begin
               system_reset_n <= 1'b1; // RULE_01
            end else begin
               rel_cnt <= rel_cnt + 32'h0000_0001; // RULE_14
            end
         end
      end
   end
   assign system_reset = ~system_reset_n; // RULE_04
   // ****************************************
   // push button sequencer
   // ****************************************
   assign hard_hold = !pb_q && hold_done(pb_cnt) && (pb_state == TSRS_PB_PRESS);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pb_state <= TSRS_PB_IDLE;
         pb_cnt <= 32'h0000_0000;
         soft_reset_n <= 1'b1;
      end else if (clk_en) begin
         soft_reset_n <= 1'b1;
         unique case (pb_state)
            TSRS_PB_IDLE: begin
               pb_cnt <= 32'h0000_0000;
               if (!pb_q) begin
                  pb_state <= TSRS_PB_PRESS;
               end
            end
            TSRS_PB_PRESS: begin
               if (pb_q) begin
                  pb_cnt <= 32'h0000_0000; // RULE_14
                  if (hold_done(pb_cnt) || !system_reset_n) begin
                     pb_state <= TSRS_PB_IDLE; // RULE_10
                  end else begin
                     pb_state <= TSRS_PB_DEBOUNCE;
                  end
               end else if (!hold_done(pb_cnt)) begin
                  pb_cnt <= pb_cnt + 32'h0000_0001;
               end
            end
            TSRS_PB_DEBOUNCE: begin
               if (!system_reset_n) begin
                  pb_state <= TSRS_PB_IDLE; // RULE_10
               end else if (pb_cnt >= DEBOUNCE_CYC - 1) begin // RULE_07
                  pb_cnt <= 32'h0000_0000;
                  pb_state <= TSRS_PB_PULSE;
                  soft_reset_n <= 1'b0; // RULE_06
               end else begin
                  pb_cnt <= pb_cnt + 32'h0000_0001;
               end
            end
            TSRS_PB_PULSE: begin
               if (pb_cnt >= SOFT_CYC - 1 || !system_reset_n) begin
                  pb_state <= TSRS_PB_IDLE;
               end else begin
                  pb_cnt <= pb_cnt + 32'h0000_0001;
                  soft_reset_n <= 1'b0; // RULE_06
               end
            end
         endcase
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   a_inverse_out: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
      system_reset == !system_reset_n) else $error("reset outputs not complementary");
   a_supply_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
      clk_en && supply_bad |=> !system_reset_n) else $error("reset released with bad supply");
   a_release_rise: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_01
      $rose(system_reset_n) |-> $past(rel_cnt) == RELEASE_CYC - 1) else $error("release not after delay");
   a_restart_cnt: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_03
      clk_en && (supply_bad || hard_hold) |=> rel_cnt == 0) else $error("release counter not restarted");
   a_hard_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
      clk_en && hard_hold |=> system_reset && !system_reset_n) else $error("hard reset not asserted");
   a_soft_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_10
      !system_reset_n && $past(!system_reset_n) |-> soft_reset_n) else $error("soft reset during reset");
   a_soft_start: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
      $fell(soft_reset_n) |-> $past(pb_state) == TSRS_PB_DEBOUNCE) else $error("soft pulse without debounce");
   a_soft_width: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
      $rose(soft_reset_n) && $past(system_reset_n) && $past(clk_en)
      |-> $past(pb_cnt) == SOFT_CYC - 1) else $error("soft pulse wrong width");
   a_override_5v: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_12
      track_q && !high_q |-> !en_5v && en_3v3) else $error("override selection wrong");
   a_button_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
      clk_en && pb_hold |=> !system_reset_n) else $error("button did not hold reset");
   a_override_3v3: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_13
      track_q && high_q |-> en_5v && !en_3v3) else $error("5v monitor selection wrong");
   a_soft_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
      pb_state == TSRS_PB_IDLE |-> soft_reset_n) else $error("soft reset low while idle");
   a_soft_abort: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_10
      clk_en && !system_reset_n && pb_state == TSRS_PB_DEBOUNCE |=> pb_state == TSRS_PB_IDLE) else $error("debounce kept in reset");
   a_hard_no_soft: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
      clk_en && pb_q && pb_state == TSRS_PB_PRESS && hold_done(pb_cnt) |=> pb_state == TSRS_PB_IDLE) else $error("soft after hard");
   a_debounce_len: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
      pb_state == TSRS_PB_DEBOUNCE |-> pb_cnt <= DEBOUNCE_CYC - 1) else $error("debounce count overrun");
   a_release_bound: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_14
      rel_cnt <= RELEASE_CYC - 1) else $error("release count overrun");
   a_pb_cnt_bound: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_14
      pb_cnt <= HOLD_CYC - 1) else $error("button count overrun");
   c_release: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(system_reset_n));
   c_soft: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(soft_reset_n));
   c_hard: cover property (@(posedge clk_sys) disable iff (!rst_n) hard_hold);
   c_track5: cover property (@(posedge clk_sys) disable iff (!rst_n) track_q && high_q);
   c_button_hold: cover property (@(posedge clk_sys) disable iff (!rst_n) pb_hold && supply_bad);
endmodule
`default_nettype wire

// [verif/tsrs_cpu_model.sv]
// processor side model that watches the soft reset line
`timescale 1ns/1ns
`default_nettype none
module tsrs_cpu_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic soft_reset_n,
   output logic [31:0] soft_count,
   output logic [31:0] soft_width
);
   logic [31:0] run;
   // counts soft pulses, keeps width of the last one
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         soft_count <= 32'h0000_0000;
         soft_width <= 32'h0000_0000;
         run <= 32'h0000_0000;
      end else if (!soft_reset_n) begin
         run <= run + 32'h0000_0001;
         if (run == 32'h0000_0000) soft_count <= soft_count + 32'h0000_0001;
      end else if (run != 32'h0000_0000) begin
         soft_width <= run;
         run <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// [verif/tsrs_top_bench.sv]
// self-checking bench for the triple supply reset sequencer
`timescale 1ns/1ns
`default_nettype none
module tsrs_top_bench;
   // ****************
   // stimulus and checks
   // ****************
   localparam int R = 50, D = 20, H = 100, S = 10, U = 3;
   localparam logic [31:0] T1 = 32'h0000_0001, T0 = 32'h0000_0000;
   logic clk_sys = 0, rst_n = 0, clk_en = 1, ok3 = 1, ok5 = 1, oka = 1, trk = 0, abv = 0, pb_n = 1;
   logic srn, sr, ssn;
   logic [31:0] n_soft, w_soft;
   int errors = 0, n_tests = 0, n;
   always #50 clk_sys = ~clk_sys;
   tsrs_top #(.RELEASE_CYC(R), .DEBOUNCE_CYC(D), .HOLD_CYC(H), .SOFT_CYC(S), .UV_CYC(U)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .sense_3v3_ok(ok3), .sense_5v_ok(ok5),
      .sense_adjustable_ok(oka), .sense_5v_tracks_3v3(trk), .sense_5v_above_4v15(abv),
      .push_button_n(pb_n), .system_reset_n(srn), .system_reset(sr), .soft_reset_n(ssn));
   tsrs_cpu_model u_cpu (.clk_sys(clk_sys), .rst_n(rst_n), .soft_reset_n(ssn),
      .soft_count(n_soft), .soft_width(w_soft));
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(negedge clk_sys);
   endtask
   // cycles until soft (sel=1) or system reset reaches level v
   task till(input logic sel, input logic v, output int k);
      k = 0;
      while ((sel ? ssn : srn) !== v && k < 5000) begin
         cyc(1);
         k++;
      end
   endtask
   task win(input string what, input int k, input int lo, input int hi);
      chk(what, 32'(k >= lo && k <= hi), T1);
   endtask
   task t_power;
      rst_n = 1;
      till(1'b0, 1'b1, n);
      win("release delay", n, R, R + 12);
      chk("active high idle", 32'(sr), T0);
      $display("test power up done");
   endtask
   task t_dip;
      ok3 = 0;
      cyc(1);
      ok3 = 1;
      cyc(20);
      chk("short glitch", 32'(srn), T1);
      oka = 0;
      till(1'b0, 1'b0, n);
      win("dip response", n, U + 1, U + 8);
      chk("active high set", 32'(sr), T1);
      cyc(30);
      chk("held while low", 32'(srn), T0);
      oka = 1;
      till(1'b0, 1'b1, n);
      win("restart delay", n, R, R + 12);
      $display("test supply dip done");
   endtask
   task t_freeze;
      oka = 0;
      till(1'b0, 1'b0, n);
      oka = 1;
      cyc(20);
      clk_en = 0;
      cyc(R + 20);
      chk("frozen release", 32'(srn), T0);
      clk_en = 1;
      till(1'b0, 1'b1, n);
      win("resumed release", n, R - 20, R - 10);
      $display("test clock enable done");
   endtask
   task t_soft;
      pb_n = 0;
      cyc(10);
      pb_n = 1;
      till(1'b1, 1'b0, n);
      win("debounce", n, D, D + 10);
      cyc(S + 5);
      chk("soft count", n_soft, T1);
      chk("soft width", w_soft, 32'(S));
      $display("test soft press done");
   endtask
   task t_hard;
      pb_n = 0;
      till(1'b0, 1'b0, n);
      win("hold time", n, H, H + 8);
      chk("hard active high", 32'(sr), T1);
      cyc(20);
      pb_n = 1;
      till(1'b0, 1'b1, n);
      win("hard release", n, R, R + 10);
      cyc(D + S + 10);
      chk("no soft after hard", n_soft, T1);
      $display("test hard press done");
   endtask
   task t_override;
      trk = 1;
      ok5 = 0;
      cyc(30);
      chk("5v ignored", 32'(srn), T1);
      abv = 1;
      till(1'b0, 1'b0, n);
      win("5v enabled", n, 1, U + 8);
      ok5 = 1;
      ok3 = 0;
      till(1'b0, 1'b1, n);
      win("3v3 ignored", n, R, R + 14);
      ok3 = 1;
      cyc(10);
      trk = 0;
      abv = 0;
      cyc(10);
      chk("override cleared", 32'(srn), T1);
      $display("test override done");
   endtask
   task t_supply_pb;
      ok3 = 0;
      cyc(20);
      pb_n = 0;
      cyc(20);
      ok3 = 1;
      cyc(R + 10);
      chk("held by button", 32'(srn), T0);
      pb_n = 1;
      till(1'b0, 1'b1, n);
      win("button release", n, R, R + 12);
      cyc(D + S + 10);
      chk("soft suppressed", n_soft, T1);
      $display("test supply with button done");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      cyc(5);
      t_power;
      t_dip;
      t_freeze;
      t_soft;
      t_hard;
      t_override;
      t_supply_pb;
      end_sim;
   end
   initial begin
      cyc(3000);
      errors++;
      end_sim;
   end
endmodule
`default_nettype wire
